// *** sli_map.svh ***
// Constants for the status LED indicator: sizes and flash timing
`ifndef SLI_MAP_SVH
`define SLI_MAP_SVH

// Number of output channels, one bicolor LED each
`define SLI_NUM_CHAN      16

// System clock rate in MHz (5 ns period)
`define SLI_CLK_MHZ       200

// Flash half period in milliseconds (on time equals off time)
`define SLI_FLASH_HALF_MS 250

// Width of the flash period counter, wide enough for the default half period
`define SLI_FLASH_CNT_W   26

// Reset value of the two-stage power synchroniser: powered
`define SLI_PWR_SYNC_RST  2'h3

`endif

// *** sli_pkg.sv ***
// Types shared by the status LED indicator modules
`include "sli_map.svh"
`default_nettype none

package sli_pkg;

	// What the module health LED is showing
	typedef enum logic [2:0] {
		HS_DARK,
		HS_BOOT_RED,
		HS_GREEN,
		HS_GREEN_FLASH,
		HS_RED,
		HS_RED_FLASH
	} sli_health_type;

	// Module state reported by firmware, all levels on sys_clk
	typedef struct packed {
		logic fw_ctrl;        // Firmware has taken over the health LED
		logic conn_ok;        // Connection to the owning controller exists
		logic nonrec_fault;   // Nonrecoverable fault seen
		logic fw_update_busy; // Firmware update in progress
		logic fw_update_fail; // Last firmware update attempt failed
		logic recov_fault;    // Recoverable fault present
		logic conn_timeout;   // Controller connection timed out
	} sli_mod_status_type;

	// Per-channel fault conditions that flash the channel LED red
	typedef struct packed {
		logic open_load;
		logic short_circ;
		logic field_loss;
	} sli_chan_fault_type;

	// Red/green health LED drive, high lights the colour
	typedef struct packed {
		logic red;
		logic green;
	} sli_led_rg_type;

	// Red/yellow channel LED drive, high lights the colour
	typedef struct packed {
		logic red;
		logic yellow;
	} sli_led_ry_type;

	// State of the flash period generator
	typedef struct packed {
		logic [`SLI_FLASH_CNT_W-1:0] count;
		logic                        phase;
	} sli_flash_state_type;

	// State of one channel LED driver
	typedef struct packed {
		sli_led_ry_type led;
	} sli_chan_state_type;

	// State of the top-level indicator logic
	typedef struct packed {
		logic [1:0]     pwr_sync;
		logic           fw_owned;
		logic           dead;
		sli_health_type health;
		sli_led_rg_type led;
	} sli_main_state_type;

endpackage

`default_nettype wire

// *** sli_flash.sv ***
// Flash phase generator: one counter shared by every flashing indication
`include "sli_map.svh"
`default_nettype none

module sli_flash #(
	parameter int unsigned HALF_CYCLES = 32'd50000000
) (
	input  wire logic sys_clk, // System clock
	input  wire logic srst,    // Synchronous reset, active high
	output var  logic phase    // Flash phase, high in the lit half
);
	import sli_pkg::*;

	localparam logic [`SLI_FLASH_CNT_W-1:0] LAST = `SLI_FLASH_CNT_W'(HALF_CYCLES - 1);

	sli_flash_state_type st_reg;
	sli_flash_state_type st_next;

	// Equal halves keep the duty cycle even
	always_comb begin
		st_next = st_reg;
		if (st_reg.count >= LAST) begin // R11
			st_next.count = '0;
			st_next.phase = ~st_reg.phase;
		end else begin
			st_next.count = st_reg.count + `SLI_FLASH_CNT_W'(1);
		end
	end

	// Reset starts in the lit half
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg <= '{count: '0, phase: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end

	assign phase = st_reg.phase;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_flash_toggle_point: assert property ($changed(phase) |-> $past(st_reg.count) == LAST) // R11
		else $error("flash phase changed away from the period end");
	a_flash_count_bound: assert property (st_reg.count <= LAST) // R11
		else $error("flash counter ran past its last value");

endmodule

`default_nettype wire

// *** sli_chan.sv ***
// One red/yellow channel LED driver
`default_nettype none

module sli_chan (
	input  wire logic                        sys_clk,     // System clock
	input  wire logic                        srst,        // Synchronous reset, active high
	input  wire logic                        pwr_ok,      // Module power present, synchronised
	input  wire logic                        chan_on,     // Channel switched on
	input  wire sli_pkg::sli_chan_fault_type chan_fault,  // Flashing fault causes
	input  wire logic                        mcu_red,     // Firmware fault lamp request
	input  wire logic                        flash_phase, // Shared flash phase
	output var  sli_pkg::sli_led_ry_type     led          // LED drive, registered
);
	import sli_pkg::*;

	sli_chan_state_type st_reg;
	sli_chan_state_type st_next;

	// Off or unpowered is dark; detected faults outrank the firmware lamp
	always_comb begin
		st_next     = '0;
		if (pwr_ok && chan_on) begin // R3
			if (|chan_fault) begin
				st_next.led.red = flash_phase; // R5
			end else if (mcu_red) begin
				st_next.led.red = 1'b1; // R4
			end else begin
				st_next.led.yellow = 1'b1; // R2
			end
		end
	end

	// Dark out of reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign led = st_reg.led;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_chan_on_yellow: assert property ( // R2
		pwr_ok && chan_on && !(|chan_fault) && !mcu_red |=> led.yellow && !led.red)
		else $error("active channel without fault not steady yellow");
	a_chan_off_dark: assert property ((!pwr_ok || !chan_on) |=> led == '0) // R3
		else $error("channel LED lit while off or unpowered");
	a_chan_mcu_red: assert property ( // R4
		pwr_ok && chan_on && !(|chan_fault) && mcu_red |=> led.red && !led.yellow)
		else $error("firmware fault lamp not shown red");
	a_chan_flash_red: assert property ( // R5
		pwr_ok && chan_on && (|chan_fault) |=> led.red == $past(flash_phase) && !led.yellow)
		else $error("detected channel fault not flashing red");

endmodule

`default_nettype wire

// *** sli_status_led.sv ***
// Top of the status LED indicator: health LED and sixteen channel LEDs
`include "sli_map.svh"
`default_nettype none

// Function
// R1 - Health LED red from power-up until firmware
// R2 - Sixteen channel LEDs, steady yellow when on
// R3 - Channel LED dark when off or unpowered
// R4 - Firmware can light channel red for fault
// R5 - Open load, short, field loss flash red
// R6 - Health LED off without module power
// R7 - Steady green when connected and normal
// R8 - Flashing green without controller connection
// R9 - Steady red after nonrecoverable fault, sticky
// R10 - Flashing red: update, failed update, faults, timeout
// R11 - One flash counter; highest severity wins
module sli_status_led #(
	parameter int unsigned FLASH_HALF_CYCLES =
		32'(`SLI_FLASH_HALF_MS) * 32'(`SLI_CLK_MHZ) * 32'd1000 // Flash half period
) (
	input  wire logic                                        sys_clk,       // System clock
	input  wire logic                                        srst,          // Sync reset
	input  wire logic                                        mod_power_ok,  // Power sense pin
	input  wire sli_pkg::sli_mod_status_type                 mod_status,    // Firmware state
	input  wire logic [`SLI_NUM_CHAN-1:0]                    chan_on,       // Channel on
	input  wire sli_pkg::sli_chan_fault_type [`SLI_NUM_CHAN-1:0] chan_fault, // Fault causes
	input  wire logic [`SLI_NUM_CHAN-1:0]                    chan_mcu_red,  // Fault lamp
	output var  sli_pkg::sli_led_rg_type                     health_led,    // Health LED
	output var  sli_pkg::sli_health_type                     health_state,  // Shown state
	output var  sli_pkg::sli_led_ry_type [`SLI_NUM_CHAN-1:0] chan_led       // Channel LEDs
);
	import sli_pkg::*;

	// Any cause of the flashing red health indication
	function automatic logic red_flash_cause(input sli_mod_status_type s);
		red_flash_cause = s.fw_update_busy | s.fw_update_fail | s.recov_fault
			| s.conn_timeout; // R10
	endfunction

	// Colour drive for a health state at the current flash phase
	function automatic sli_led_rg_type health_drive(input sli_health_type h, input logic ph);
		sli_led_rg_type d;
		d = '0;
		unique case (h)
			HS_DARK:        d = '0;
			HS_BOOT_RED:    d.red = 1'b1;
			HS_GREEN:       d.green = 1'b1;
			HS_GREEN_FLASH: d.green = ph;
			HS_RED:         d.red = 1'b1;
			HS_RED_FLASH:   d.red = ph;
			default:        d = '0;
		endcase
		health_drive = d;
	endfunction

	sli_main_state_type st_reg;
	sli_main_state_type st_next;
	logic               flash_phase;
	logic               pwr;
	logic               owned_now;
	logic               dead_now;
	logic               cause_now;

	// Shared flash phase; every flashing LED blinks in step
	sli_flash #(
		.HALF_CYCLES (FLASH_HALF_CYCLES)
	) u_flash (
		.sys_clk (sys_clk),
		.srst    (srst),
		.phase   (flash_phase) // R11
	);

	// Power sense is a pin, so only the second stage is read
	assign pwr       = st_reg.pwr_sync[1];
	assign owned_now = st_reg.fw_owned | mod_status.fw_ctrl;
	assign dead_now  = st_reg.dead | mod_status.nonrec_fault;
	assign cause_now = red_flash_cause(mod_status);

	// Health state, ordered from most to least severe
	always_comb begin
		st_next          = st_reg;
		st_next.pwr_sync = {st_reg.pwr_sync[0], mod_power_ok};
		if (!pwr) begin
			// Losing power is the power cycle that clears the sticky fault
			st_next.fw_owned = 1'b0;
			st_next.dead     = 1'b0;
			st_next.health   = HS_DARK; // R6
		end else begin
			st_next.fw_owned = owned_now; // R1
			st_next.dead     = dead_now; // R9
			if (!owned_now) begin
				st_next.health = HS_BOOT_RED; // R1
			end else if (dead_now) begin
				st_next.health = HS_RED; // R9
			end else if (cause_now) begin
				st_next.health = HS_RED_FLASH; // R10
			end else if (!mod_status.conn_ok) begin
				st_next.health = HS_GREEN_FLASH; // R8
			end else begin
				st_next.health = HS_GREEN; // R7
			end
		end
		st_next.led = health_drive(st_next.health, flash_phase); // R11
	end

	// Reset shows boot red at once; a missing supply darkens it three cycles later
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg <= '{
				pwr_sync: `SLI_PWR_SYNC_RST,
				fw_owned: 1'b0,
				dead:     1'b0,
				health:   HS_BOOT_RED,
				led:      '{red: 1'b1, green: 1'b0}
			};
		end else begin
			st_reg <= st_next;
		end
	end

	assign health_led   = st_reg.led;
	assign health_state = st_reg.health;

	// Channel drivers; a channel can only show what its own inputs say
	for (genvar i = 0; i < `SLI_NUM_CHAN; i++) begin : g_chan
		sli_chan u_chan (
			.sys_clk     (sys_clk),
			.srst        (srst),
			.pwr_ok      (pwr), // R3
			.chan_on     (chan_on[i]), // R2
			.chan_fault  (chan_fault[i]), // R5
			.mcu_red     (chan_mcu_red[i]), // R4
			.flash_phase (flash_phase), // R11
			.led         (chan_led[i])
		);
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// Pin held high for two cycles reaches the logic; low twice darkens the LED
	sequence s_pin_high2;
		mod_power_ok [*2];
	endsequence

	sequence s_pin_low2;
		!mod_power_ok [*2];
	endsequence

	// Normal running conditions with firmware in charge
	sequence s_running;
		pwr && owned_now && !dead_now && !cause_now;
	endsequence

	a_power_sync_high: assert property (s_pin_high2 |=> pwr) // R6
		else $error("power sense not seen after two high samples");
	a_power_loss_dark: assert property (s_pin_low2 |=> ##1 health_led == '0) // R6
		else $error("health LED not dark after power loss");
	a_health_off: assert property (!pwr |=> health_led == '0 && health_state == HS_DARK) // R6
		else $error("health LED lit without module power");
	a_boot_red: assert property ( // R1
		pwr && !st_reg.fw_owned && !mod_status.fw_ctrl |=> health_led.red && !health_led.green)
		else $error("health LED not red before firmware control");
	a_owned_sticky: assert property ( // R1
		pwr && st_reg.fw_owned |=> st_reg.fw_owned || !$past(pwr))
		else $error("firmware ownership dropped while powered");
	a_health_green: assert property ( // R7
		s_running and mod_status.conn_ok |=> health_led.green && !health_led.red)
		else $error("connected normal module not steady green");
	a_green_flash: assert property ( // R8
		s_running and !mod_status.conn_ok |=>
			health_led.green == $past(flash_phase) && !health_led.red)
		else $error("unconnected module not flashing green");
	a_dead_sticky: assert property ( // R9
		pwr && mod_status.nonrec_fault ##1 pwr [*3] |-> st_reg.dead)
		else $error("nonrecoverable fault cleared without power cycle");
	a_dead_red: assert property ( // R9
		pwr && owned_now && dead_now |=> health_led.red && !health_led.green
			&& health_state == HS_RED)
		else $error("nonrecoverable fault not steady red");
	a_red_flash: assert property ( // R10
		pwr && owned_now && !dead_now && cause_now |=>
			health_led.red == $past(flash_phase) && !health_led.green)
		else $error("recoverable condition not flashing red");
	a_severity_order: assert property ( // R11
		pwr && owned_now && cause_now && !mod_status.conn_ok && !dead_now |=>
			health_state == HS_RED_FLASH)
		else $error("lower severity indication shown over red flash");
	a_flash_common: assert property ( // R11
		health_state == HS_GREEN_FLASH |-> health_led.green == $past(flash_phase))
		else $error("green flash out of step with shared phase");

	// Power returning after an absence, seen at the synchroniser output
	sequence s_power_back;
		!pwr ##1 pwr;
	endsequence

	// Firmware claiming the health LED for the first time in a power cycle
	sequence s_take_over;
		pwr && !st_reg.fw_owned && mod_status.fw_ctrl;
	endsequence

	// Nonrecoverable fault reported while the module is powered
	sequence s_fault_hit;
		pwr && mod_status.nonrec_fault;
	endsequence

	// Connection lost while running normally
	sequence s_conn_drop;
		s_running ##0 mod_status.conn_ok ##1 s_running ##0 !mod_status.conn_ok;
	endsequence

	// A steady state shown on two edges in a row
	sequence s_held_green;
		health_state == HS_GREEN ##1 health_state == HS_GREEN;
	endsequence

	sequence s_held_red;
		health_state == HS_RED ##1 health_state == HS_RED;
	endsequence

	// Synchroniser stages move one edge apart; logic reads only the second
	a_sync_stage_one: assert property ( // R6
		1'b1 |=> st_reg.pwr_sync[0] == $past(mod_power_ok))
		else $error("first power sync stage missed the pin");
	a_sync_stage_two: assert property ( // R6
		1'b1 |=> st_reg.pwr_sync[1] == $past(st_reg.pwr_sync[0]))
		else $error("second power sync stage missed the first");

	// Each shown state lights exactly the colour it names
	a_one_colour: assert property (!(health_led.red && health_led.green)) // R11
		else $error("health LED driven red and green together");
	a_dark_drive: assert property (health_state == HS_DARK |-> health_led == '0) // R6
		else $error("dark health state with a lit LED");
	a_boot_drive: assert property ( // R1
		health_state == HS_BOOT_RED |-> health_led.red && !health_led.green)
		else $error("boot state not shown red");
	a_green_drive: assert property ( // R7
		health_state == HS_GREEN |-> health_led.green && !health_led.red)
		else $error("green state not shown green");
	a_green_flash_drive: assert property ( // R8
		health_state == HS_GREEN_FLASH |-> !health_led.red)
		else $error("green flash state shows red");
	a_red_drive: assert property ( // R9
		health_state == HS_RED |-> health_led.red && !health_led.green)
		else $error("red state not shown red");
	a_red_flash_drive: assert property ( // R10
		health_state == HS_RED_FLASH |->
			health_led.red == $past(flash_phase) && !health_led.green)
		else $error("red flash out of step with shared phase");

	// Steady means steady: no flicker while the state holds
	a_green_steady: assert property (s_held_green |-> $stable(health_led)) // R7
		else $error("steady green LED changed");
	a_red_steady: assert property (s_held_red |-> $stable(health_led)) // R9
		else $error("steady red LED changed");
	a_phase_hold: assert property ($changed(flash_phase) |=> $stable(flash_phase)) // R11
		else $error("flash phase toggled on two edges in a row");

	// Latches take effect on the first edge that sees their cause, and only then
	a_owned_set: assert property (s_take_over |=> st_reg.fw_owned) // R1
		else $error("firmware control not latched");
	a_owned_needs_ctrl: assert property ( // R1
		!st_reg.fw_owned && !(pwr && mod_status.fw_ctrl) |=> !st_reg.fw_owned)
		else $error("firmware control latched without a request");
	a_dead_set: assert property (s_fault_hit |=> st_reg.dead) // R9
		else $error("nonrecoverable fault not latched");
	a_dead_needs_fault: assert property ( // R9
		!st_reg.dead && !(pwr && mod_status.nonrec_fault) |=> !st_reg.dead)
		else $error("fault latched without a report");
	a_power_clears: assert property (!pwr |=> !st_reg.dead && !st_reg.fw_owned) // R9
		else $error("power loss did not clear the latched state");
	a_repower_boot: assert property ( // R1
		s_power_back ##0 !mod_status.fw_ctrl |=> health_state == HS_BOOT_RED)
		else $error("returning power did not restart in boot red");
	a_conn_lost: assert property (s_conn_drop |=> health_state == HS_GREEN_FLASH) // R8
		else $error("lost connection not shown as green flash");

	// Severity order: not owned, then latched fault, then the flashing causes
	a_boot_over_all: assert property (pwr && !owned_now |=> health_state == HS_BOOT_RED) // R1
		else $error("indication shown before firmware control");
	a_dead_over_flash: assert property ( // R11
		pwr && owned_now && dead_now && cause_now |=> health_state == HS_RED)
		else $error("red flash shown over nonrecoverable fault");

	// Without module power no channel may light, whatever it reports
	a_chan_unpowered: assert property (!pwr |=> chan_led == '0) // R3
		else $error("channel LED lit without module power");

	// Per-channel checks here, where the shared phase and health LED are visible
	for (genvar i = 0; i < `SLI_NUM_CHAN; i++) begin : g_chan_chk
		a_chan_in_step: assert property ( // R11
			pwr && chan_on[i] && (|chan_fault[i]) && owned_now && !dead_now && cause_now
				|=> chan_led[i].red == health_led.red)
			else $error("channel flash out of step with health flash");
		a_chan_idle_dark: assert property (!chan_on[i] |=> chan_led[i] == '0) // R3
			else $error("switched off channel LED lit");
		a_chan_own_lamp: assert property ( // R4
			pwr && chan_on[i] && chan_mcu_red[i] && !(|chan_fault[i])
				|=> chan_led[i] == 2'b10)
			else $error("fault lamp not shown on its own channel");
		a_chan_steady: assert property ( // R2
			(pwr && chan_on[i] && !(|chan_fault[i]) && !chan_mcu_red[i]) [*2]
				|=> chan_led[i] == 2'b01 && $stable(chan_led[i]))
			else $error("steady yellow channel LED changed");
	end

endmodule

`default_nettype wire

// *** sli_led_panel.sv ***
// Indicator panel model: counts the lit cycles of one chosen LED
`include "sli_map.svh"
`default_nettype none

module sli_led_panel (
	input  wire logic                                        sys_clk,    // System clock
	input  wire logic                                        clr,        // Restart counts
	input  wire logic [4:0]                                  sel,        // 0-15 chan, 16 health
	input  wire sli_pkg::sli_led_rg_type                     health_led, // Health LED drive
	input  wire sli_pkg::sli_led_ry_type [`SLI_NUM_CHAN-1:0] chan_led,   // Channel drives
	output var  logic [7:0]                                  red_cnt,    // Cycles red lit
	output var  logic [7:0]                                  oth_cnt     // Green/yellow lit
);
	import sli_pkg::*;
	logic red_on;
	logic oth_on;

	// An LED has no memory: it shows this cycle's drive only
	always_comb begin
		red_on = sel[4] ? health_led.red : chan_led[sel[3:0]].red;
		oth_on = sel[4] ? health_led.green : chan_led[sel[3:0]].yellow;
	end

	// Counting over whole flash periods makes duty exact
	always_ff @(posedge sys_clk) begin
		if (clr) begin
			red_cnt <= 8'h00;
			oth_cnt <= 8'h00;
		end else begin
			red_cnt <= red_cnt + 8'(red_on);
			oth_cnt <= oth_cnt + 8'(oth_on);
		end
	end
endmodule

`default_nettype wire

// *** status_led_indicator_tb.sv ***
// Self-checking bench for the status LED indicator
`include "sli_map.svh"
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end

module status_led_indicator_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import sli_pkg::*;
	localparam int HALF = 8;       // Short flash half period for sim
	localparam int WIN  = 4 * HALF; // Two full flash periods
	logic                                       sys_clk = 1'b0;
	logic                                       srst    = 1'b1;
	logic                                       mod_power_ok = 1'b1;
	sli_mod_status_type                         mod_status = '0;
	logic [`SLI_NUM_CHAN-1:0]                   chan_on = '0;
	sli_chan_fault_type [`SLI_NUM_CHAN-1:0]     chan_fault = '0;
	logic [`SLI_NUM_CHAN-1:0]                   chan_mcu_red = '0;
	sli_led_rg_type                             health_led;
	sli_health_type                             health_state;
	sli_led_ry_type [`SLI_NUM_CHAN-1:0]         chan_led;
	logic                                       clr = 1'b0;
	logic [4:0]                                 sel = 5'h10;
	logic [7:0]                                 red_cnt;
	logic [7:0]                                 oth_cnt;
	int                                         n_fail = 0;
	int                                         checks = 0;

	sli_status_led #(.FLASH_HALF_CYCLES(HALF)) dut_u (.sys_clk(sys_clk), .srst(srst),
		.mod_power_ok(mod_power_ok), .mod_status(mod_status), .chan_on(chan_on),
		.chan_fault(chan_fault), .chan_mcu_red(chan_mcu_red), .health_led(health_led),
		.health_state(health_state), .chan_led(chan_led));
	sli_led_panel panel_u (.sys_clk(sys_clk), .clr(clr), .sel(sel), .health_led(health_led),
		.chan_led(chan_led), .red_cnt(red_cnt), .oth_cnt(oth_cnt));

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;

	task automatic close_out();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Settle point just after the n-th edge, never on it
	task automatic look(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic set_st(input logic [6:0] s);
		@(posedge sys_clk);
		mod_status <= s;
		look(1);
	endtask

	task automatic chk_h(input sli_health_type st, input sli_led_rg_type ld, input string nm);
		`CHK({nm, " state"}, st, health_state)
		`CHK({nm, " led"}, ld, health_led)
	endtask

	// Counts lit cycles of one LED over two flash periods
	task automatic measure(input logic [4:0] s, input logic [7:0] er, input logic [7:0] eo);
		@(posedge sys_clk);
		sel <= s;
		clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
		look(WIN);
		`CHK("red cycles", er, red_cnt)
		`CHK("lit cycles", eo, oth_cnt)
	endtask

	task automatic t_boot();
		chk_h(HS_BOOT_RED, 2'b10, "boot");
		`CHK("chan off", 32'h0, chan_led)
		set_st(7'b0100000);
		chk_h(HS_BOOT_RED, 2'b10, "unowned");
	endtask

	task automatic t_chan();
		@(posedge sys_clk);
		chan_on <= 16'hffff;
		look(1);
		`CHK("all yellow", 32'h5555_5555, chan_led)
		// Channel 0 off with fault and lamp request must stay dark
		@(posedge sys_clk);
		chan_on <= 16'hfffe;
		chan_fault[0] <= 3'b010;
		chan_mcu_red <= 16'h0021;
		look(1);
		`CHK("off dark", 2'b00, chan_led[0])
		`CHK("lamp red", 2'b10, chan_led[5])
		measure(5'd5, 8'd32, 8'd0);
		@(posedge sys_clk);
		chan_on <= 16'hffff;
		chan_fault[0] <= 3'b000;
		chan_mcu_red <= 16'h0200;
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk);
			chan_fault[9] <= 3'b001 << k;
			measure(5'd9, 8'd16, 8'd0);
			`CHK("neighbour", 2'b01, chan_led[8])
		end
		@(posedge sys_clk);
		chan_fault <= '0;
		chan_mcu_red <= '0;
	endtask

	task automatic t_health();
		set_st(7'b1100000);
		chk_h(HS_GREEN, 2'b01, "green");
		measure(5'h10, 8'd0, 8'd32);
		set_st(7'b1000000);
		`CHK("no conn", HS_GREEN_FLASH, health_state)
		measure(5'h10, 8'd0, 8'd16);
		// Each cause alone, with no connection to outrank; channel 3 flashes alongside
		@(posedge sys_clk);
		chan_fault[3] <= 3'b100;
		for (int i = 0; i < 4; i++) begin
			set_st(7'b1000000 | (7'b0000001 << i));
			`CHK("red flash", HS_RED_FLASH, health_state)
			measure(5'h10, 8'd16, 8'd0);
		end
		measure(5'd3, 8'd16, 8'd0);
		@(posedge sys_clk);
		chan_fault[3] <= 3'b000;
		set_st(7'b0100000);
		chk_h(HS_GREEN, 2'b01, "owned kept");
	endtask

	task automatic t_dead();
		set_st(7'b1110000);
		chk_h(HS_RED, 2'b10, "dead");
		set_st(7'b1100010);
		chk_h(HS_RED, 2'b10, "dead kept");
		measure(5'h10, 8'd32, 8'd0);
		@(posedge sys_clk);
		mod_power_ok <= 1'b0;
		mod_status <= '0;
		look(3);
		chk_h(HS_DARK, 2'b00, "no power");
		`CHK("chan unpowered", 32'h0, chan_led)
		@(posedge sys_clk);
		mod_power_ok <= 1'b1;
		look(3);
		chk_h(HS_BOOT_RED, 2'b10, "repower");
		set_st(7'b1100000);
		chk_h(HS_GREEN, 2'b01, "cleared");
	endtask

	// Watchdog: whole run needs well under 2000 cycles
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_fail++;
		close_out();
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		#1;
		t_boot();
		t_chan();
		t_health();
		t_dead();
		close_out();
	end
endmodule

`default_nettype wire
